// File: hdl/simd_pkg.sv
// package: shared types and constants of the packed integer datapath
package simd_pkg;

  // ----------------------------------------------------------------
  // widths
  // ----------------------------------------------------------------
  localparam int VEC_W      = 128;  // wide vector register
  localparam int NARROW_W   = 64;   // narrow vector register
  localparam int QUAD_W     = 64;
  localparam int DWORD_W    = 32;
  localparam int WORD_W     = 16;
  localparam int BYTE_W     = 8;
  localparam int IMM_W      = 8;
  localparam int SEL_W      = 2;    // one shuffle selector
  localparam int ADDR_W     = 64;

  // ----------------------------------------------------------------
  // alignment, shift and timing figures
  // ----------------------------------------------------------------
  localparam int ALIGN_BYTES     = 16;
  localparam int ALIGN_BITS      = 4;   // log2 of ALIGN_BYTES
  localparam int MAX_SHIFT_BYTES = 15;
  localparam int LATENCY         = 1;   // request edge to answer
  localparam logic [VEC_W-1:0] RESET_DATA = '0;

  // ----------------------------------------------------------------
  // operation codes
  // ----------------------------------------------------------------
  typedef enum logic [4:0] {
    OP_NOP              = 5'b0_0000,
    OP_ALIGNED_MOVE     = 5'b0_0001,  // aligned_wide_move
    OP_UNALIGNED_MOVE   = 5'b0_0010,  // unaligned_wide_move
    OP_QUAD_ADD         = 5'b0_0011,  // quad_lane_add
    OP_QUAD_SUB         = 5'b0_0100,  // quad_lane_subtract
    OP_UMUL             = 5'b0_0101,  // unsigned_dword_multiply
    OP_LOW_WORD_SHUF    = 5'b0_0110,
    OP_HIGH_WORD_SHUF   = 5'b0_0111,
    OP_DWORD_SHUF       = 5'b0_1000,
    OP_LEGACY_WORD_SHUF = 5'b0_1001,
    OP_SHIFT_LEFT       = 5'b0_1010,  // whole_byte_shift_left
    OP_SHIFT_RIGHT      = 5'b0_1011,  // whole_byte_shift_right
    OP_HIGH_INTERLEAVE  = 5'b0_1100,
    OP_LOW_INTERLEAVE   = 5'b0_1101,
    OP_NARROW_TO_WIDE   = 5'b0_1110,
    OP_WIDE_TO_NARROW   = 5'b0_1111,
    OP_LANE_ADD         = 5'b1_0000,  // byte_lane_add and kin
    OP_LANE_SUB         = 5'b1_0001
  } op_t;

  // lane size of the generic add and subtract
  typedef enum logic [1:0] {
    SZ_BYTE  = 2'b00,
    SZ_WORD  = 2'b01,
    SZ_DWORD = 2'b10,
    SZ_QUAD  = 2'b11
  } size_t;

  // ----------------------------------------------------------------
  // request from the decoder, answer to the register file
  // ----------------------------------------------------------------
  typedef struct packed {
    logic               valid;
    op_t                op;
    logic               wide;      // 1: wide form, 0: narrow form
    size_t              size;
    logic               from_mem;  // b operand is memory data
    logic [ADDR_W-1:0]  addr;
    logic [IMM_W-1:0]   imm;
    logic [VEC_W-1:0]   a;         // destination's current value
    logic [VEC_W-1:0]   b;         // source value
  } req_t;

  typedef struct packed {
    logic               valid;
    logic               wr_en;
    logic               wide;      // destination file
    logic               fault;     // protection_fault
    logic               illegal;
    logic [VEC_W-1:0]   data;
  } rsp_t;

endpackage

// File: hdl/lane_addsub.sv
// module: lane-partitioned add and subtract with no carry across lanes
module lane_addsub #(
  parameter int WIDTH = 128
) (
  // operands
  input  wire logic [WIDTH-1:0] a,
  input  wire logic [WIDTH-1:0] b,
  // controls
  input  wire logic             sub,
  input  wire simd_pkg::size_t  size,
  // result
  output logic      [WIDTH-1:0] sum
);
  import simd_pkg::*;

  localparam int NBYTES = WIDTH / BYTE_W;

  // lane starts come from byte index bits, so whole quadwords only
  if (WIDTH % QUAD_W != 0 || WIDTH < QUAD_W) begin : g_bad_width
    $error("lane_addsub: WIDTH must be a multiple of 64");
  end

  logic [NBYTES:0] carry;
  logic [2:0]      start_mask;

  // low index bits that must be zero at the start of a lane
  assign start_mask = 3'((4'b0001 << size) - 4'b0001);
  assign carry[0]   = sub;

  // one byte slice per step; a lane start takes the fresh carry-in
  // so lanes wrap on their own with no saturation
  for (genvar gi = 0; gi < NBYTES; gi++) begin : g_byte
    localparam logic [2:0] IDX = 3'(gi);
    logic       cin;
    logic [7:0] bx;
    assign cin = ((IDX & start_mask) == 3'b000) ? sub : carry[gi];
    assign bx  = b[BYTE_W*gi +: BYTE_W] ^ {BYTE_W{sub}};
    assign {carry[gi+1], sum[BYTE_W*gi +: BYTE_W]} =
      9'(a[BYTE_W*gi +: BYTE_W]) + 9'(bx) + 9'(cin);
  end

endmodule

// File: hdl/simd_integer_datapath.sv
// module: packed integer execution datapath, one answer per request
module simd_integer_datapath (
  // clock and reset
  input  wire logic           mclk,
  input  wire logic           rst_n,
  // request from the decoder
  input  wire simd_pkg::req_t req,
  // answer to the register file
  output simd_pkg::rsp_t      rsp
);
  import simd_pkg::*;

  // ----------------------------------------------------------------
  // elaboration checks
  // ----------------------------------------------------------------

  // the pickers, the multiply lanes and the shift count assume these
  // exact ratios; any other package figures would alias silently
  if (VEC_W != 2 * QUAD_W || QUAD_W != 4 * WORD_W ||
      VEC_W != 4 * DWORD_W || IMM_W != 4 * SEL_W) begin : g_bad_width
    $error("simd_integer_datapath: lane widths do not fit");
  end
  if (ALIGN_BYTES != (1 << ALIGN_BITS) ||
      MAX_SHIFT_BYTES != VEC_W / BYTE_W - 1) begin : g_bad_figure
    $error("simd_integer_datapath: alignment or shift figure wrong");
  end

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------

  typedef struct packed {
    rsp_t rsp;
  } state_t;

  state_t st_ff;
  state_t nxt_st;

  // ----------------------------------------------------------------
  // element pickers
  // ----------------------------------------------------------------

  // word sel of a quadword
  function automatic logic [WORD_W-1:0] pick_word(
    input logic [QUAD_W-1:0] q,
    input logic [SEL_W-1:0]  sel
  );
    pick_word = WORD_W'(q >> {sel, 4'h0});
  endfunction

  // doubleword sel of a wide register
  function automatic logic [DWORD_W-1:0] pick_dword(
    input logic [VEC_W-1:0] v,
    input logic [SEL_W-1:0] sel
  );
    pick_dword = DWORD_W'(v >> {sel, 5'h00});
  endfunction

  // ----------------------------------------------------------------
  // operand views
  // ----------------------------------------------------------------

  logic [QUAD_W-1:0] a_lo;
  logic [QUAD_W-1:0] a_hi;
  logic [QUAD_W-1:0] b_lo;
  logic [QUAD_W-1:0] b_hi;

  assign a_lo = req.a[QUAD_W-1:0];
  assign a_hi = req.a[VEC_W-1:QUAD_W];
  assign b_lo = req.b[QUAD_W-1:0];
  assign b_hi = req.b[VEC_W-1:QUAD_W];

  // ----------------------------------------------------------------
  // lane add and subtract
  // ----------------------------------------------------------------

  logic [VEC_W-1:0] as_sum;
  logic             as_sub;
  size_t            as_size;

  // quadword forms are the generic adder at quadword lane size
  always_comb begin
    as_sub  = (req.op == OP_QUAD_SUB) || (req.op == OP_LANE_SUB);
    as_size = req.size;
    if (req.op == OP_QUAD_ADD || req.op == OP_QUAD_SUB) begin
      as_size = SZ_QUAD;
    end
  end

  // one adder serves all lane sizes; narrow forms simply drop the
  // high half afterwards, which costs a little power but no area
  lane_addsub #(
    .WIDTH (VEC_W)
  ) u_addsub (
    .a    (req.a),
    .b    (req.b),
    .sub  (as_sub),
    .size (as_size),
    .sum  (as_sum)
  );

  // ----------------------------------------------------------------
  // unsigned doubleword multiply
  // ----------------------------------------------------------------

  logic [VEC_W-1:0] mul_res;

  // lane g multiplies doubleword 2g of both sources
  for (genvar gi = 0; gi < 2; gi++) begin : g_mul
    logic [QUAD_W-1:0] ma;
    logic [QUAD_W-1:0] mb;
    assign ma = {32'h0000_0000, req.a[QUAD_W*gi +: DWORD_W]};
    assign mb = {32'h0000_0000, req.b[QUAD_W*gi +: DWORD_W]};
    assign mul_res[QUAD_W*gi +: QUAD_W] = ma * mb;
  end

  // ----------------------------------------------------------------
  // shuffles
  // ----------------------------------------------------------------

  logic [QUAD_W-1:0] lo_shuf;
  logic [QUAD_W-1:0] hi_shuf;
  logic [VEC_W-1:0]  d_shuf;

  // destination element g takes the element named by imm[2g+1:2g]
  for (genvar gi = 0; gi < 4; gi++) begin : g_shuf
    logic [SEL_W-1:0] sel;
    assign sel = req.imm[SEL_W*gi +: SEL_W];
    assign lo_shuf[WORD_W*gi +: WORD_W] =
      pick_word(b_lo, sel);
    assign hi_shuf[WORD_W*gi +: WORD_W] =
      pick_word(b_hi, sel);
    assign d_shuf[DWORD_W*gi +: DWORD_W] =
      pick_dword(req.b, sel);
  end

  // ----------------------------------------------------------------
  // whole-register byte shifts
  // ----------------------------------------------------------------

  logic [6:0]       sh_bits;
  logic             sh_over;
  logic [VEC_W-1:0] shl_res;
  logic [VEC_W-1:0] shr_res;

  // counts past the register width must not alias back into range
  assign sh_bits = {req.imm[3:0], 3'b000};
  assign sh_over = req.imm > IMM_W'(MAX_SHIFT_BYTES);

  always_comb begin
    shl_res = req.b << sh_bits;
    shr_res = req.b >> sh_bits;
    if (sh_over) begin
      shl_res = RESET_DATA;
      shr_res = RESET_DATA;
    end
  end

  // ----------------------------------------------------------------
  // alignment check
  // ----------------------------------------------------------------

  logic addr_low_set;
  logic misaligned;

  // only the low address bits matter for a 16-byte boundary; a move
  // between registers carries no address and never faults
  assign addr_low_set = req.addr[ALIGN_BITS-1:0] != '0;
  assign misaligned   = req.from_mem && addr_low_set;

  // ----------------------------------------------------------------
  // width legality
  // ----------------------------------------------------------------

  logic wide_only;
  logic narrow_only;
  logic width_bad;

  // the word, doubleword and whole-register ops have no narrow form
  // and the legacy word shuffle has no wide one; moves choose their
  // destination file themselves and accept either width flag
  always_comb begin
    wide_only   = 1'b0;
    narrow_only = 1'b0;
    case (req.op)
      OP_LOW_WORD_SHUF, OP_HIGH_WORD_SHUF, OP_DWORD_SHUF,
      OP_SHIFT_LEFT, OP_SHIFT_RIGHT,
      OP_HIGH_INTERLEAVE, OP_LOW_INTERLEAVE: begin
        wide_only = 1'b1;
      end
      OP_LEGACY_WORD_SHUF: begin
        narrow_only = 1'b1;
      end
      default: begin
        wide_only   = 1'b0;
        narrow_only = 1'b0;
      end
    endcase
  end

  // a form the op does not have is refused, never silently remapped
  assign width_bad = (wide_only && !req.wide) ||
                     (narrow_only && req.wide);

  // ----------------------------------------------------------------
  // result select
  // ----------------------------------------------------------------

  logic [VEC_W-1:0] res;
  logic             res_wide;
  logic             res_fault;
  logic             res_bad;

  // result and destination file of the decoded op
  always_comb begin
    res       = RESET_DATA;
    res_wide  = req.wide;
    res_fault = 1'b0;
    res_bad   = 1'b0;
    case (req.op)
      OP_ALIGNED_MOVE: begin
        res       = req.b;
        res_wide  = 1'b1;
        res_fault = misaligned;
      end
      OP_UNALIGNED_MOVE: begin
        res      = req.b;
        res_wide = 1'b1;
      end
      OP_QUAD_ADD, OP_QUAD_SUB: begin
        res       = as_sum;
      end
      OP_LANE_ADD, OP_LANE_SUB: begin
        res       = as_sum;
      end
      OP_UMUL: begin
        res       = mul_res;
      end
      OP_LOW_WORD_SHUF: begin
        res = {b_hi, lo_shuf};
      end
      OP_HIGH_WORD_SHUF: begin
        res = {hi_shuf, b_lo};
      end
      OP_DWORD_SHUF: begin
        res = d_shuf;
      end
      OP_LEGACY_WORD_SHUF: begin
        // only a narrow destination exists for this one
        res      = {64'h0000_0000_0000_0000, lo_shuf};
        res_wide = 1'b0;
      end
      OP_SHIFT_LEFT: begin
        res = shl_res;
      end
      OP_SHIFT_RIGHT: begin
        res = shr_res;
      end
      OP_HIGH_INTERLEAVE: begin
        res = {b_hi, a_hi};
      end
      OP_LOW_INTERLEAVE: begin
        res = {b_lo, a_lo};
      end
      OP_NARROW_TO_WIDE: begin
        res      = {64'h0000_0000_0000_0000, b_lo};
        res_wide = 1'b1;
      end
      OP_WIDE_TO_NARROW: begin
        res      = {64'h0000_0000_0000_0000, b_lo};
        res_wide = 1'b0;
      end
      default: begin
        res_bad = 1'b1;
      end
    endcase
    // an op asked in a width it does not have is refused
    if (width_bad) begin
      res_bad = 1'b1;
    end
    // narrow forms keep one quadword; the high half reads as zero
    if (!res_wide) begin
      res[VEC_W-1:QUAD_W] = '0;
    end
  end

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------

  // a faulting or refused request answers but writes nothing back,
  // so the destination keeps its old value
  always_comb begin
    nxt_st              = st_ff;
    nxt_st.rsp.valid    = req.valid;
    nxt_st.rsp.fault    = req.valid && res_fault;
    nxt_st.rsp.illegal  = req.valid && res_bad;
    nxt_st.rsp.wr_en    = req.valid && !res_fault && !res_bad;
    nxt_st.rsp.wide     = res_wide;
    nxt_st.rsp.data     = res;
    if (!req.valid) begin
      nxt_st.rsp.wide = 1'b0;
      nxt_st.rsp.data = RESET_DATA;
    end
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------

  // synchronous reset clears every answer field
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign rsp = st_ff.rsp;

endmodule

// File: tb/dec_rf_model.sv
// partner: decoder launching requests and a register file taking answers
module dec_rf_model
  import simd_pkg::*;
(
  // clock and reset
  input  wire logic           mclk,
  input  wire logic           rst_n,
  // next request chosen by the bench
  input  wire simd_pkg::req_t stim,
  // decoder side
  output simd_pkg::req_t      req,
  // register file side
  input  wire simd_pkg::rsp_t rsp,
  output logic [127:0]        wide_reg,
  output logic [63:0]         narrow_reg
);
  timeunit 1ns;
  timeprecision 1ps;

  initial req = '0;

  // ------------------------------------------------------------------
  // launch and write back
  // ------------------------------------------------------------------
  // requests change just after the edge and stand a whole cycle;
  // nothing is launched while the core is held in reset
  always @(posedge mclk) begin
    req <= rst_n ? stim : '0;
    if (!rst_n) begin
      wide_reg   <= '0;
      narrow_reg <= '0;
    end else begin
      if (rsp.valid && rsp.wr_en && rsp.wide)
        wide_reg <= rsp.data;
      if (rsp.valid && rsp.wr_en && !rsp.wide)
        narrow_reg <= rsp.data[63:0];
    end
  end
endmodule

// File: tb/simd_dp_chk.sv
// checker: answer relations of the packed integer datapath
module simd_dp_chk
  import simd_pkg::*;
(
  // clock and reset
  input wire logic           mclk,
  input wire logic           rst_n,
  // request and answer
  input wire simd_pkg::req_t req,
  input wire simd_pkg::rsp_t rsp
);
  timeunit 1ns;
  timeprecision 1ps;

  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);

  // ------------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------------
  a_misalign_faults: assert property (
    req.valid && req.op == OP_ALIGNED_MOVE && req.from_mem
    && req.addr[3:0] != 4'h0 |=> rsp.valid && rsp.fault && !rsp.wr_en)
    else $error("misaligned move not faulted");
  a_unaligned_ok: assert property (
    req.valid && req.op == OP_UNALIGNED_MOVE
    |=> !rsp.fault && rsp.wr_en && rsp.data == $past(req.b))
    else $error("unaligned move wrong");
  a_quad_add_lanes: assert property (
    req.valid && req.op == OP_QUAD_ADD && req.wide
    |=> rsp.data == {$past(req.a[127:64] + req.b[127:64]),
                     $past(req.a[63:0] + req.b[63:0])})
    else $error("wide quad add wrong");
  a_quad_sub_narrow: assert property (
    req.valid && req.op == OP_QUAD_SUB && !req.wide
    |=> !rsp.wide && rsp.data == {64'h0, $past(req.a[63:0] - req.b[63:0])})
    else $error("narrow quad subtract wrong");
  a_umul_pairs: assert property (
    req.valid && req.op == OP_UMUL && req.wide
    |=> rsp.data == {$past(64'(req.a[95:64]) * 64'(req.b[95:64])),
                     $past(64'(req.a[31:0]) * 64'(req.b[31:0]))})
    else $error("wide multiply wrong");
  a_big_shift_zero: assert property (
    req.valid && req.wide && req.imm > 8'h0f
    && req.op inside {OP_SHIFT_LEFT, OP_SHIFT_RIGHT} |=> rsp.data == '0)
    else $error("long byte shift not zero");
  a_widen_clears: assert property (
    req.valid && req.op == OP_NARROW_TO_WIDE
    |=> rsp.wide && rsp.data == {64'h0, $past(req.b[63:0])})
    else $error("narrow to wide move wrong");
  a_legacy_refused: assert property (
    req.valid && req.op == OP_LEGACY_WORD_SHUF && req.wide
    |=> rsp.valid && rsp.illegal && !rsp.wr_en)
    else $error("wide legacy shuffle accepted");
  a_idle_quiet: assert property (
    !req.valid ##1 rst_n |-> rsp == '0)
    else $error("answer without request");

  // ------------------------------------------------------------------
  // covers
  // ------------------------------------------------------------------
  c_fault: cover property (rsp.fault);
  c_refused: cover property (rsp.illegal);
  c_back_to_back: cover property (rsp.valid [*3]);
endmodule

bind simd_integer_datapath simd_dp_chk chk_i (
  .mclk(mclk), .rst_n(rst_n), .req(req), .rsp(rsp));

// File: tb/simd_integer_datapath_tb.sv
// testbench: corner and random requests against a reference model
module simd_integer_datapath_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import simd_pkg::*;

  logic        mclk = 1'b0;
  logic        rst_n = 1'b0;
  req_t        stim = '0;
  req_t        req;
  rsp_t        rsp;
  rsp_t        exp_q = '0;
  int          n_errors = 0;
  int          samples_checked = 0;
  int          cyc = 0;
  logic [63:0] seed = 64'h0000_0000_0000_0011;
  logic [127:0] wide_reg;
  logic [63:0]  narrow_reg;
  logic [127:0] exp_wide = '0;
  logic [63:0]  exp_narrow = '0;
  logic [7:0]   shv [5] = '{8'h00, 8'h01, 8'h0f, 8'h10, 8'hff};

  always #2 mclk = ~mclk;

  dec_rf_model model_i (.mclk(mclk), .rst_n(rst_n), .stim(stim),
    .req(req), .rsp(rsp), .wide_reg(wide_reg), .narrow_reg(narrow_reg));
  simd_integer_datapath uut (.mclk(mclk), .rst_n(rst_n), .req(req),
    .rsp(rsp));

  // ------------------------------------------------------------------
  // reference
  // ------------------------------------------------------------------
  function automatic logic [63:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 7;
    seed ^= seed << 17;
    return seed;
  endfunction

  function automatic logic [127:0] rv();
    return {xs(), xs()};
  endfunction

  // four 2-bit selectors, lowest destination word first
  function automatic logic [63:0] wsh(logic [63:0] q, logic [7:0] s);
    logic [63:0] o;
    for (int g = 0; g < 4; g++)
      o[16*g+:16] = q[16*s[2*g+:2]+:16];
    return o;
  endfunction

  function automatic rsp_t ref_rsp(req_t r);
    rsp_t         e;
    logic [127:0] a;
    logic [127:0] b;
    logic [127:0] d;
    logic [127:0] m;
    int           n;
    e = '0;
    a = r.a;
    b = r.b;
    d = '0;
    e.valid = 1'b1;
    e.wide = r.wide;
    case (r.op)
      OP_ALIGNED_MOVE, OP_UNALIGNED_MOVE: begin
        d = b;
        e.wide = 1'b1;
        e.fault = r.op == OP_ALIGNED_MOVE && r.from_mem
                  && r.addr[3:0] != 4'h0;
      end
      OP_QUAD_ADD: d = {a[127:64] + b[127:64], a[63:0] + b[63:0]};
      OP_QUAD_SUB: d = {a[127:64] - b[127:64], a[63:0] - b[63:0]};
      OP_UMUL: d = {64'(a[95:64]) * 64'(b[95:64]),
                    64'(a[31:0]) * 64'(b[31:0])};
      OP_LOW_WORD_SHUF: d = {b[127:64], wsh(b[63:0], r.imm)};
      OP_HIGH_WORD_SHUF: d = {wsh(b[127:64], r.imm), b[63:0]};
      OP_LEGACY_WORD_SHUF: d = {64'h0, wsh(b[63:0], r.imm)};
      OP_DWORD_SHUF: begin
        for (int g = 0; g < 4; g++)
          d[32*g+:32] = b[32*r.imm[2*g+:2]+:32];
      end
      OP_SHIFT_LEFT: d = r.imm > 8'h0f ? '0 : b << (8 * r.imm);
      OP_SHIFT_RIGHT: d = r.imm > 8'h0f ? '0 : b >> (8 * r.imm);
      OP_HIGH_INTERLEAVE: d = {b[127:64], a[127:64]};
      OP_LOW_INTERLEAVE: d = {b[63:0], a[63:0]};
      OP_NARROW_TO_WIDE: begin
        d = {64'h0, b[63:0]};
        e.wide = 1'b1;
      end
      OP_WIDE_TO_NARROW: begin
        d = {64'h0, b[63:0]};
        e.wide = 1'b0;
      end
      OP_LANE_ADD, OP_LANE_SUB: begin
        n = 8 << r.size;
        m = '1 >> (128 - n);
        for (int i = 0; i < 128; i += n)
          d |= ((r.op == OP_LANE_SUB ? (a >> i) - (b >> i)
                 : (a >> i) + (b >> i)) & m) << i;
      end
      default: e.illegal = 1'b1;
    endcase
    if (!r.wide && r.op inside {OP_QUAD_ADD, OP_QUAD_SUB, OP_UMUL,
                                OP_LANE_ADD, OP_LANE_SUB})
      d[127:64] = 64'h0;
    if ((r.op == OP_LEGACY_WORD_SHUF && r.wide) || (!r.wide && r.op
        inside {OP_LOW_WORD_SHUF, OP_HIGH_WORD_SHUF, OP_DWORD_SHUF,
        OP_SHIFT_LEFT, OP_SHIFT_RIGHT, OP_HIGH_INTERLEAVE,
        OP_LOW_INTERLEAVE}))
      e.illegal = 1'b1;
    e.wr_en = !(e.fault || e.illegal);
    e.data = d;
    return e;
  endfunction

  // ------------------------------------------------------------------
  // checking
  // ------------------------------------------------------------------
  task automatic cmp(string what, logic [127:0] e, logic [127:0] g);
    samples_checked++;
    if (e !== g) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", what, e, g);
    end
  endtask

  task automatic complete_run();
    $display("errors %0d checks %0d", n_errors, samples_checked);
    if (n_errors == 0 && samples_checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // expectation follows the request the design takes at this edge
  always @(posedge mclk) begin
    cyc++;
    exp_q <= (rst_n && req.valid) ? ref_rsp(req) : '0;
    // the register file writes back the answer that stands now;
    // faulted or refused answers must leave it untouched
    if (!rst_n) begin
      exp_wide   <= '0;
      exp_narrow <= '0;
    end else if (exp_q.wr_en && exp_q.wide) begin
      exp_wide <= exp_q.data;
    end else if (exp_q.wr_en) begin
      exp_narrow <= exp_q.data[63:0];
    end
    if (cyc > 2000) begin
      n_errors++;
      complete_run();
    end
  end

  // the answer stands one cycle, so look at it mid-cycle
  always @(negedge mclk) begin
    if (rst_n) begin
      cmp("flags", 128'({exp_q.valid, exp_q.wr_en, exp_q.fault,
          exp_q.illegal}), 128'({rsp.valid, rsp.wr_en, rsp.fault,
          rsp.illegal}));
      if (!exp_q.illegal) begin
        cmp("wide", 128'(exp_q.wide), 128'(rsp.wide));
        cmp("data", exp_q.data, rsp.data);
      end
      cmp("wide file", exp_wide, wide_reg);
      cmp("narrow file", 128'(exp_narrow), 128'(narrow_reg));
    end
  end

  // ------------------------------------------------------------------
  // stimulus
  // ------------------------------------------------------------------
  task automatic mk(op_t o, logic w, logic [7:0] i, logic fm,
                    logic [63:0] ad, logic [127:0] a, logic [127:0] b);
    @(posedge mclk);
    stim <= '{valid: 1'b1, op: o, wide: w, size: size_t'(xs()),
              from_mem: fm, addr: ad, imm: i, a: a, b: b};
  endtask

  initial begin
    repeat (8) @(posedge mclk);
    rst_n <= 1'b1;
    mk(OP_ALIGNED_MOVE, 1, 0, 1, 64'h8, rv(), rv());
    mk(OP_ALIGNED_MOVE, 1, 0, 1, 64'h10, rv(), rv());
    mk(OP_ALIGNED_MOVE, 1, 0, 0, 64'h4, rv(), rv());
    mk(OP_UNALIGNED_MOVE, 1, 0, 1, 64'h3, rv(), rv());
    mk(OP_QUAD_ADD, 1, 0, 0, 0, '1, {64'h1, 64'h1});
    mk(OP_QUAD_ADD, 0, 0, 0, 0, rv(), rv());
    mk(OP_QUAD_SUB, 1, 0, 0, 0, '0, {64'h1, 64'h1});
    mk(OP_QUAD_SUB, 0, 0, 0, 0, rv(), rv());
    mk(OP_UMUL, 0, 0, 0, 0, '1, '1);
    mk(OP_UMUL, 1, 0, 0, 0, '1, rv());
    mk(OP_LOW_WORD_SHUF, 1, 8'h1b, 0, 0, rv(), rv());
    mk(OP_HIGH_WORD_SHUF, 1, 8'he4, 0, 0, rv(), rv());
    mk(OP_DWORD_SHUF, 1, 8'h4e, 0, 0, rv(), rv());
    mk(OP_LEGACY_WORD_SHUF, 0, 8'h39, 0, 0, rv(), rv());
    mk(OP_LEGACY_WORD_SHUF, 1, 8'h39, 0, 0, rv(), rv());
    mk(OP_DWORD_SHUF, 0, 8'h39, 0, 0, rv(), rv());
    foreach (shv[k]) begin
      mk(OP_SHIFT_LEFT, 1, shv[k], 0, 0, rv(), rv());
      mk(OP_SHIFT_RIGHT, 1, shv[k], 0, 0, rv(), rv());
    end
    mk(OP_HIGH_INTERLEAVE, 1, 0, 0, 0, rv(), rv());
    mk(OP_LOW_INTERLEAVE, 1, 0, 0, 0, rv(), rv());
    mk(OP_NARROW_TO_WIDE, 0, 0, 0, 0, rv(), rv());
    mk(OP_WIDE_TO_NARROW, 1, 0, 0, 0, rv(), rv());
    mk(op_t'(5'h1f), 1, 0, 0, 0, rv(), rv());
    for (int s = 0; s < 8; s++)
      mk(s[2] ? OP_LANE_SUB : OP_LANE_ADD, s[0], 0, 0, 0, '1,
         rv());
    for (int k = 0; k < 300; k++)
      mk(op_t'(5'(1 + xs() % 17)), xs() % 2, 8'(xs()), xs() % 2,
         xs(), rv(), rv());
    @(posedge mclk);
    stim <= '0;
    repeat (4) @(posedge mclk);
    complete_run();
  end
endmodule
